// ---- rtl/pin_remap_pkg.sv ----
// Constants for the remappable pin output multiplexer.
// Assumes one system clock domain and no register bus.
package pin_remap_pkg;
  localparam int unsigned PIN_COUNT    = 8;
  localparam int unsigned SEL_W        = 6;
  localparam int unsigned SRC_COUNT    = 64;
  localparam logic [SEL_W-1:0] SEL_RESET   = 6'h00;
  // Output selector codes
  localparam logic [SEL_W-1:0] SEL_DEFAULT = 6'h00;
  localparam logic [SEL_W-1:0] SEL_SER1_TX = 6'h01;
  localparam logic [SEL_W-1:0] SEL_SER2_TX = 6'h03;
  localparam logic [SEL_W-1:0] SEL_SP2_DO  = 6'h08;
  localparam logic [SEL_W-1:0] SEL_SP2_CK  = 6'h09;
  localparam logic [SEL_W-1:0] SEL_SP2_SS  = 6'h0a;
  localparam logic [SEL_W-1:0] SEL_COD_DO  = 6'h0b;
  localparam logic [SEL_W-1:0] SEL_COD_CK  = 6'h0c;
  localparam logic [SEL_W-1:0] SEL_COD_FS  = 6'h0d;
  localparam logic [SEL_W-1:0] SEL_CAN1_TX = 6'h0e;
  localparam logic [SEL_W-1:0] SEL_CAN2_TX = 6'h0f;
  localparam logic [SEL_W-1:0] SEL_CMP_OUT = 6'h10;
  localparam logic [SEL_W-1:0] SEL_CMPR1   = 6'h18;
  localparam logic [SEL_W-1:0] SEL_CMPR2   = 6'h19;
  localparam logic [SEL_W-1:0] SEL_CMPR3   = 6'h1a;
  localparam logic [SEL_W-1:0] SEL_SER3_TX = 6'h1b;
  localparam logic [SEL_W-1:0] SEL_SER3_RS = 6'h1c;
  localparam logic [SEL_W-1:0] SEL_SER4_TX = 6'h1d;
  localparam logic [SEL_W-1:0] SEL_SER4_RS = 6'h1e;
  localparam logic [SEL_W-1:0] SEL_SP3_DO  = 6'h1f;
  localparam logic [SEL_W-1:0] SEL_SP3_CK  = 6'h20;
  localparam logic [SEL_W-1:0] SEL_SP3_SS  = 6'h21;
  localparam logic [SEL_W-1:0] SEL_PWM_S1  = 6'h2d;
  localparam logic [SEL_W-1:0] SEL_PWM_S2  = 6'h2e;
  localparam logic [SEL_W-1:0] SEL_ENC1    = 6'h2f;
  localparam logic [SEL_W-1:0] SEL_ENC2    = 6'h30;
  localparam logic [SEL_W-1:0] SEL_REFCLK  = 6'h31;
  localparam logic [SEL_W-1:0] SEL_CMPR4   = 6'h32;
  localparam logic [SEL_W-1:0] SEL_CMPR5   = 6'h33;
  localparam int unsigned COMPARE_COUNT = 8;
  // Analog select resets to analog mode, direction to input
  localparam logic [PIN_COUNT-1:0] ANALOG_RESET = 8'hff;
  localparam logic [PIN_COUNT-1:0] DIR_RESET    = 8'hff;
endpackage

// ---- rtl/remappable_pin_output_mux.sv ----
// Remappable pin output multiplexer with pin-function arbitration.
// Assumes peripheral outputs and config come from core_clk logic; pin inputs are asynchronous.
`timescale 1ns/100ps
module remappable_pin_output_mux
  import pin_remap_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       arst_n,
  input  wire logic [PIN_COUNT*SEL_W-1:0] pin_output_select,
  input  wire logic [PIN_COUNT-1:0]       analog_select,
  input  wire logic [PIN_COUNT-1:0]       pin_direction,
  input  wire logic [PIN_COUNT-1:0]       output_latch,
  input  wire logic [PIN_COUNT-1:0]       dedicated_out_en,
  input  wire logic [PIN_COUNT-1:0]       dedicated_out,
  input  wire logic                       core_overvoltage_detect,
  input  wire logic                       serial1_transmit,
  input  wire logic                       serial2_transmit,
  input  wire logic                       serial3_transmit,
  input  wire logic                       serial3_ready_to_send,
  input  wire logic                       serial4_transmit,
  input  wire logic                       serial4_ready_to_send,
  input  wire logic                       sync_port2_data_out,
  input  wire logic                       sync_port2_clock_out,
  input  wire logic                       sync_port2_select_out,
  input  wire logic                       sync_port3_data_out,
  input  wire logic                       sync_port3_clock_out,
  input  wire logic                       sync_port3_select_out,
  input  wire logic                       codec_data_out,
  input  wire logic                       codec_clock_out,
  input  wire logic                       codec_frame_sync,
  input  wire logic                       can1_transmit,
  input  wire logic                       can2_transmit,
  input  wire logic [COMPARE_COUNT-1:0]   compare_out,
  input  wire logic [4:0]                 comparator_out,
  input  wire logic                       pwm_primary_sync_out,
  input  wire logic                       pwm_secondary_sync_out,
  input  wire logic                       encoder1_compare_out,
  input  wire logic                       encoder2_compare_out,
  input  wire logic                       reference_clock_out,
  input  wire logic [PIN_COUNT-1:0]       remappable_pin_in,
  output logic      [PIN_COUNT-1:0]       remappable_pin_out,
  output logic      [PIN_COUNT-1:0]       remappable_pin_oe,
  output logic      [PIN_COUNT-1:0]       pin_level_read,
  output logic      [PIN_COUNT-1:0]       digital_in_enable
);

  // Source table indexed by selector code; unlisted codes read as idle
  logic [SRC_COUNT-1:0] src_vec;
  logic [SRC_COUNT-1:0] src_valid;
  always_comb begin
    src_vec   = '0;
    src_valid = '0;
    src_vec[SEL_SER1_TX] = serial1_transmit;
    src_vec[SEL_SER2_TX] = serial2_transmit;
    src_vec[SEL_SP2_DO]  = sync_port2_data_out;
    src_vec[SEL_SP2_CK]  = sync_port2_clock_out;
    src_vec[SEL_SP2_SS]  = sync_port2_select_out;
    src_vec[SEL_COD_DO]  = codec_data_out;
    src_vec[SEL_COD_CK]  = codec_clock_out;
    src_vec[SEL_COD_FS]  = codec_frame_sync;
    src_vec[SEL_CAN1_TX] = can1_transmit;
    src_vec[SEL_CAN2_TX] = can2_transmit;
    for (int i = 0; i < COMPARE_COUNT; i++) begin
      src_vec[int'(SEL_CMP_OUT) + i]   = compare_out[i];
      src_valid[int'(SEL_CMP_OUT) + i] = 1'b1;
    end
    src_vec[SEL_CMPR1]   = comparator_out[0];
    src_vec[SEL_CMPR2]   = comparator_out[1];
    src_vec[SEL_CMPR3]   = comparator_out[2];
    src_vec[SEL_CMPR4]   = comparator_out[3];
    src_vec[SEL_CMPR5]   = comparator_out[4];
    src_vec[SEL_SER3_TX] = serial3_transmit;
    src_vec[SEL_SER3_RS] = serial3_ready_to_send;
    src_vec[SEL_SER4_TX] = serial4_transmit;
    src_vec[SEL_SER4_RS] = serial4_ready_to_send;
    src_vec[SEL_SP3_DO]  = sync_port3_data_out;
    src_vec[SEL_SP3_CK]  = sync_port3_clock_out;
    src_vec[SEL_SP3_SS]  = sync_port3_select_out;
    src_vec[SEL_PWM_S1]  = pwm_primary_sync_out;
    src_vec[SEL_PWM_S2]  = pwm_secondary_sync_out;
    src_vec[SEL_ENC1]    = encoder1_compare_out;
    src_vec[SEL_ENC2]    = encoder2_compare_out;
    src_vec[SEL_REFCLK]  = reference_clock_out;
    // Codes that map to a peripheral; all others act as default
    src_valid[SEL_SER1_TX] = 1'b1;
    src_valid[SEL_SER2_TX] = 1'b1;
    for (int c = int'(SEL_SP2_DO); c <= int'(SEL_CAN2_TX); c++) begin
      src_valid[c] = 1'b1;
    end
    for (int c = int'(SEL_CMPR1); c <= int'(SEL_SP3_SS); c++) begin
      src_valid[c] = 1'b1;
    end
    for (int c = int'(SEL_PWM_S1); c <= int'(SEL_CMPR5); c++) begin
      src_valid[c] = 1'b1;
    end
  end

  // Two-flop synchroniser on pin inputs
  logic [PIN_COUNT-1:0] sync1_q;
  logic [PIN_COUNT-1:0] sync2_q;
  logic [PIN_COUNT-1:0] sync1_d;
  logic [PIN_COUNT-1:0] sync2_d;
  always_comb begin
    sync1_d = remappable_pin_in;
    sync2_d = sync1_q;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // Registered pin drive, enable and read-back
  logic [PIN_COUNT-1:0] out_q;
  logic [PIN_COUNT-1:0] oe_q;
  logic [PIN_COUNT-1:0] rd_q;
  logic [PIN_COUNT-1:0] out_d;
  logic [PIN_COUNT-1:0] oe_d;
  logic [PIN_COUNT-1:0] rd_d;
  logic [PIN_COUNT-1:0] remap_act;
  logic [PIN_COUNT-1:0] remap_val;

  // Per-pin output arbitration; selectors are independent
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
    logic [SEL_W-1:0] sel;
    assign sel          = pin_output_select[p*SEL_W +: SEL_W];
    assign remap_act[p] = (sel != SEL_DEFAULT) && src_valid[sel];
    assign remap_val[p] = src_vec[sel];
  end

  always_comb begin
    for (int p = 0; p < PIN_COUNT; p++) begin
      // Dedicated first, then remappable, then port latch
      if (dedicated_out_en[p]) begin
        out_d[p] = dedicated_out[p];
        oe_d[p]  = 1'b1;
      end else if (remap_act[p]) begin
        out_d[p] = remap_val[p];
        oe_d[p]  = 1'b1;
      end else begin
        out_d[p] = output_latch[p];
        oe_d[p]  = !pin_direction[p];
      end
      // Overvoltage forces every pin off the wire
      if (core_overvoltage_detect) begin
        oe_d[p] = 1'b0;
      end
      // Only analog select gates the input buffer
      rd_d[p] = !analog_select[p] && sync2_q[p];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_q <= '0;
      oe_q  <= '0;
      rd_q  <= '0;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
      rd_q  <= rd_d;
    end
  end

  assign remappable_pin_out = out_q;
  assign remappable_pin_oe  = oe_q;
  assign pin_level_read     = rd_q;
  assign digital_in_enable  = ~analog_select;

  // Checks
  a_ovd_tristate: assert property (@(posedge core_clk) disable iff (!arst_n)
    core_overvoltage_detect |=> remappable_pin_oe == '0) else $error("pin driven during overvoltage");
  a_analog_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    analog_select[0] |=> pin_level_read[0] == 1'b0) else $error("analog pin read nonzero");
  a_ded_wins: assert property (@(posedge core_clk) disable iff (!arst_n)
    dedicated_out_en[0] && !core_overvoltage_detect |=> remappable_pin_oe[0] &&
    remappable_pin_out[0] == $past(dedicated_out[0])) else $error("dedicated output lost");
  a_remap_tx1: assert property (@(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[0] && pin_output_select[SEL_W-1:0] == SEL_SER1_TX |=>
    remappable_pin_out[0] == $past(serial1_transmit)) else $error("serial1 not routed");
  a_remap_oe: assert property (@(posedge core_clk) disable iff (!arst_n)
    remap_act[1] && !core_overvoltage_detect |=> remappable_pin_oe[1]) else $error("remap ignored direction");
  a_default_dir: assert property (@(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[2] && !remap_act[2] && pin_direction[2] |=> !remappable_pin_oe[2])
    else $error("input pin driven");
  a_unassigned: assert property (@(posedge core_clk) disable iff (!arst_n)
    pin_output_select[SEL_W-1:0] == 6'h02 |-> !remap_act[0]) else $error("unassigned code routed");
  a_cmp_route: assert property (@(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[0] && pin_output_select[SEL_W-1:0] == 6'h17 |=>
    remappable_pin_out[0] == $past(compare_out[7])) else $error("compare eight not routed");
  a_digital_read: assert property (@(posedge core_clk) disable iff (!arst_n)
    !analog_select[3] [*3] |-> pin_level_read[3] == $past(remappable_pin_in[3], 3))
    else $error("digital read wrong");
  // Serial three transmit reaches pin zero
  a_route_ser3: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[0] && pin_output_select[SEL_W-1:0] == SEL_SER3_TX |=>
    remappable_pin_out[0] == $past(serial3_transmit))
    else $error("serial3 transmit not routed");
  // Serial four ready-to-send reaches pin zero
  a_route_rts4: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[0] && pin_output_select[SEL_W-1:0] == SEL_SER4_RS |=>
    remappable_pin_out[0] == $past(serial4_ready_to_send))
    else $error("serial4 ready-to-send not routed");
  // Sync port two clock reaches pin zero
  a_route_sp2: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[0] && pin_output_select[SEL_W-1:0] == SEL_SP2_CK |=>
    remappable_pin_out[0] == $past(sync_port2_clock_out))
    else $error("sync port2 clock not routed");
  // Codec frame sync reaches pin zero
  a_route_codec: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[0] && pin_output_select[SEL_W-1:0] == SEL_COD_FS |=>
    remappable_pin_out[0] == $past(codec_frame_sync))
    else $error("codec frame sync not routed");
  // Second CAN transmit reaches pin zero
  a_route_can2: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[0] && pin_output_select[SEL_W-1:0] == SEL_CAN2_TX |=>
    remappable_pin_out[0] == $past(can2_transmit))
    else $error("can2 transmit not routed");
  // Fifth comparator reaches pin zero
  a_route_cmpr5: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[0] && pin_output_select[SEL_W-1:0] == SEL_CMPR5 |=>
    remappable_pin_out[0] == $past(comparator_out[4]))
    else $error("comparator five not routed");
  // Sync port three select reaches pin zero
  a_route_sp3: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[0] && pin_output_select[SEL_W-1:0] == SEL_SP3_SS |=>
    remappable_pin_out[0] == $past(sync_port3_select_out))
    else $error("sync port3 select not routed");
  // Secondary PWM sync reaches pin zero
  a_route_pwm: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[0] && pin_output_select[SEL_W-1:0] == SEL_PWM_S2 |=>
    remappable_pin_out[0] == $past(pwm_secondary_sync_out))
    else $error("pwm secondary sync not routed");
  // First encoder compare reaches pin zero
  a_route_enc: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[0] && pin_output_select[SEL_W-1:0] == SEL_ENC1 |=>
    remappable_pin_out[0] == $past(encoder1_compare_out))
    else $error("encoder1 compare not routed");
  // Reference clock reaches pin zero
  a_route_refclk: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[0] && pin_output_select[SEL_W-1:0] == SEL_REFCLK |=>
    remappable_pin_out[0] == $past(reference_clock_out))
    else $error("reference clock not routed");
  // Analog mode still lets the latch drive
  a_analog_drive: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[1] && !remap_act[1] && !pin_direction[1] && analog_select[1] &&
    !core_overvoltage_detect |=> remappable_pin_oe[1])
    else $error("analog pin output blocked");
  // Nothing drives a pin while reset is held
  a_reset_quiet: assert property (
    @(posedge core_clk)
    !arst_n |-> remappable_pin_oe == '0)
    else $error("pin driven in reset");
  // Port latch drives an output-direction pin
  a_latch_drive: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !dedicated_out_en[2] && !remap_act[2] && !pin_direction[2] && !core_overvoltage_detect |=>
    remappable_pin_oe[2] && remappable_pin_out[2] == $past(output_latch[2]))
    else $error("latch drive lost");
  c_ovd: cover property (@(posedge core_clk) disable iff (!arst_n) core_overvoltage_detect ##1 !core_overvoltage_detect);
  c_remap: cover property (@(posedge core_clk) disable iff (!arst_n) remap_act[0] && !dedicated_out_en[0]);
  c_both: cover property (@(posedge core_clk) disable iff (!arst_n) remap_act[0] && dedicated_out_en[0]);
endmodule

// ---- verif/periph_pin_model.sv ----
// Far-side model: on-chip peripheral outputs and the board side of the pins.
// Assumes the bench sets one level per peripheral source and the board level of undriven pins.
`timescale 1ns/100ps
module periph_pin_model
  import pin_remap_pkg::*;
(
  input  wire logic [34:0]              src,
  input  wire logic [PIN_COUNT-1:0]     board_level,
  input  wire logic [PIN_COUNT-1:0]     remappable_pin_out,
  input  wire logic [PIN_COUNT-1:0]     remappable_pin_oe,
  output logic      [PIN_COUNT-1:0]     remappable_pin_in,
  output logic                          serial1_transmit,
  output logic                          serial2_transmit,
  output logic                          serial3_transmit,
  output logic                          serial3_ready_to_send,
  output logic                          serial4_transmit,
  output logic                          serial4_ready_to_send,
  output logic                          sync_port2_data_out,
  output logic                          sync_port2_clock_out,
  output logic                          sync_port2_select_out,
  output logic                          sync_port3_data_out,
  output logic                          sync_port3_clock_out,
  output logic                          sync_port3_select_out,
  output logic                          codec_data_out,
  output logic                          codec_clock_out,
  output logic                          codec_frame_sync,
  output logic                          can1_transmit,
  output logic                          can2_transmit,
  output logic      [COMPARE_COUNT-1:0] compare_out,
  output logic      [4:0]               comparator_out,
  output logic                          pwm_primary_sync_out,
  output logic                          pwm_secondary_sync_out,
  output logic                          encoder1_compare_out,
  output logic                          encoder2_compare_out,
  output logic                          reference_clock_out
);
  // Source k of the vector feeds the k-th output code in ascending code order
  assign {comparator_out[4:3], reference_clock_out, encoder2_compare_out, encoder1_compare_out,
          pwm_secondary_sync_out, pwm_primary_sync_out, sync_port3_select_out, sync_port3_clock_out,
          sync_port3_data_out, serial4_ready_to_send, serial4_transmit, serial3_ready_to_send,
          serial3_transmit, comparator_out[2:0], compare_out, can2_transmit, can1_transmit,
          codec_frame_sync, codec_clock_out, codec_data_out, sync_port2_select_out,
          sync_port2_clock_out, sync_port2_data_out, serial2_transmit, serial1_transmit} = src;
  // Pin level: the chip drives when enabled, otherwise the board decides
  assign remappable_pin_in = (remappable_pin_oe & remappable_pin_out) | (~remappable_pin_oe & board_level);
endmodule

// ---- verif/remappable_pin_output_mux_tb.sv ----
// Self-checking bench for the remappable pin output multiplexer.
// Assumes a 100 MHz core_clk; inputs change on the falling edge.
`timescale 1ns/100ps
module remappable_pin_output_mux_tb;
  import pin_remap_pkg::*;
  logic core_clk, arst_n, core_overvoltage_detect;
  logic [PIN_COUNT*SEL_W-1:0] pin_output_select;
  logic [PIN_COUNT-1:0] analog_select, pin_direction, output_latch, dedicated_out_en, dedicated_out;
  logic [PIN_COUNT-1:0] remappable_pin_in, remappable_pin_out, remappable_pin_oe, pin_level_read;
  logic [PIN_COUNT-1:0] digital_in_enable, board_level;
  logic serial1_transmit, serial2_transmit, serial3_transmit, serial3_ready_to_send, serial4_transmit;
  logic serial4_ready_to_send, sync_port2_data_out, sync_port2_clock_out, sync_port2_select_out;
  logic sync_port3_data_out, sync_port3_clock_out, sync_port3_select_out, codec_data_out;
  logic codec_clock_out, codec_frame_sync, can1_transmit, can2_transmit, pwm_primary_sync_out;
  logic pwm_secondary_sync_out, encoder1_compare_out, encoder2_compare_out, reference_clock_out;
  logic [COMPARE_COUNT-1:0] compare_out;
  logic [4:0] comparator_out;
  logic [34:0] src;
  int err_count, n_tests, cyc;
  // Output code of each peripheral source, in source order
  logic [5:0] code_tab [35] = '{6'h01, 6'h03, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f,
    6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c,
    6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h2d, 6'h2e, 6'h2f, 6'h30, 6'h31, 6'h32, 6'h33};

  remappable_pin_output_mux dut (.*);
  periph_pin_model far_side (.*);

  // Clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    {core_overvoltage_detect, dedicated_out_en, dedicated_out, output_latch, pin_output_select} = '0;
    src = '1;
    board_level = 8'hff;
    analog_select = ANALOG_RESET;
    pin_direction = DIR_RESET;
    step(20);
    chk("oe in reset", 8'h00, remappable_pin_oe);
    arst_n = 1'b1;
    step(4);
    chk("read after reset", 8'h00, pin_level_read);
    chk("input buffer reset", 8'h00, digital_in_enable);
    chk("oe zero selectors", 8'h00, remappable_pin_oe);
    $display("reset test done");
    for (int k = 0; k < 35; k++) begin
      pin_output_select = 48'(code_tab[k]) << (6 * (k % 8));
      src = 35'h1 << k;
      step(1);
      chk("route drive", 8'h01 << (k % 8), remappable_pin_out);
      chk("route enable", 8'h01 << (k % 8), remappable_pin_oe);
      src = '0;
      step(1);
      chk("route low", 8'h00, remappable_pin_out);
    end
    $display("code table test done");
    output_latch = 8'ha5;
    pin_direction = 8'h0f;
    src = '1;
    for (int c = 0; c < 64; c++) begin
      if (!(6'(c) inside {code_tab})) begin
        pin_output_select = {8{6'(c)}};
        step(1);
        chk("unassigned oe", 8'hf0, remappable_pin_oe);
        chk("unassigned out", 8'h05, remappable_pin_out & 8'h0f);
      end
    end
    $display("default port test done");
    pin_output_select = {8{6'h01}};
    step(1);
    chk("one to many", 8'hff, remappable_pin_out);
    dedicated_out_en = 8'h3c;
    pin_direction = 8'hff;
    step(1);
    chk("dedicated wins", 8'hc3, remappable_pin_out);
    chk("direction override", 8'hff, remappable_pin_oe);
    step(3);
    chk("analog read", 8'h00, pin_level_read);
    analog_select = 8'h00;
    step(4);
    chk("buffer on", 8'hff, digital_in_enable);
    chk("driven pin read", 8'hc3, pin_level_read);
    $display("priority test done");
    core_overvoltage_detect = 1'b1;
    step(4);
    chk("overvoltage oe", 8'h00, remappable_pin_oe);
    chk("board read", 8'hff, pin_level_read);
    core_overvoltage_detect = 1'b0;
    step(1);
    chk("overvoltage clear", 8'hff, remappable_pin_oe);
    $display("overvoltage test done");
    {pin_output_select, dedicated_out_en} = '0;
    board_level = 8'h5a;
    step(4);
    chk("input only pin", 8'h5a, pin_level_read);
    pin_direction = 8'h00;
    step(4);
    chk("latch drive read", 8'ha5, pin_level_read);
    arst_n = 1'b0;
    #1;
    chk("oe second reset", 8'h00, remappable_pin_oe);
    $display("input test done");
    give_verdict();
  end
endmodule
